// File: actc_clock_divider.sv
// Conversion clock enable generator driven by a five-bit divider code.
`timescale 1ns/1ps
`include "actc_defs.svh"
module actc_clock_divider #(
  parameter int CodeWidth = 5
) (
  input  wire logic                 clock,
  input  wire logic                 rst_n,
  input  wire logic [CodeWidth-1:0] dividerCode,
  input  wire logic                 restart,
  output logic                      convTick
);
  import actc_pkg::*;

  logic [CodeWidth-1:0] count;       // Bus cycles since last half period.
  logic                 phase;       // Half-period toggle of the conversion clock.
  logic [CodeWidth-1:0] next_count;
  logic                 next_phase;
  logic                 next_convTick;

  // A half period is code plus one bus cycles, so a full period is twice that.
  always_comb begin
    next_count    = count + 1'b1;
    next_phase    = phase;
    next_convTick = 1'b0;
    if (restart) begin
      next_count = '0;
      next_phase = 1'b0;
    end else if (count >= dividerCode) begin // R5
      next_count    = '0;
      next_phase    = ~phase;
      next_convTick = phase;
    end
  end

  // Registers only; restart realigns the clock so phases start cleanly.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      count    <= '0;
      phase    <= 1'b0;
      convTick <= 1'b0;
    end else begin
      count    <= next_count;
      phase    <= next_phase;
      convTick <= next_convTick;
    end
  end

  int unsigned gap;  // Bus cycles since the last tick.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      gap <= 0;
    end else if (restart) begin
      gap <= 0;            // Restart puts the divider back in its reset state.
    end else if (convTick) begin
      gap <= 1;
    end else begin
      gap <= gap + 1;
    end
  end

  // Ticks are exactly twice code plus one apart once running.
  a_tick_period: assert property (@(posedge clock) disable iff (!rst_n)
    (convTick && $stable(dividerCode) && !$past(restart) && gap > 1 && $past(gap) > 0)
    |-> gap == 2 * (int'(dividerCode) + 1)) // R5
    else $error("Conversion clock period wrong.");
endmodule // actc_clock_divider

// File: actc_defs.svh
// Constants for the ADC timing and resolution control block.
// Notes on behaviour
// [R1] Register write aborts sequence, stays idle.
// [R2] Bit 7 set selects 8-bit, else 10-bit.
// [R3] Sample phase codes give 2,4,8,16 periods.
// [R4] Fixed two-period first phase precedes second.
// [R5] Divisor is two times code plus one.
// [R6] Divider code resets to five, divide twelve.
// [R7] Software keeps conversion clock at most 2 MHz; the bench runs it at 3.125 MHz or faster.
// [R8] Software keeps conversion clock at least 500 kHz.
// [R9] Resolution and phase reset cleared; always accessible.
// [R10] Ten-bit results placed left or right justified.
// [R11] Register-write abort clears result slot counter.
`ifndef ACTC_DEFS_SVH
`define ACTC_DEFS_SVH
`define ACTC_OFS_TIMING   8'h00
`define ACTC_OFS_CONTROL  8'h04
`define ACTC_OFS_STATUS   8'h08
`define ACTC_OFS_RESULT   8'h0C
`define ACTC_TIMING_RESET 8'h05
`define ACTC_BIT_LOWRES   7
`define ACTC_SMP_HI       6
`define ACTC_SMP_LO       5
`define ACTC_PRS_HI       4
`define ACTC_BIT_START    0
`define ACTC_BIT_JUSTIFY  1
`define ACTC_FIRST_PHASE  5'h02
`define ACTC_CONV_BITS10  5'h0A
`define ACTC_CONV_BITS8   5'h08
`define ACTC_RESP_OKAY    2'h0
`define ACTC_RESP_SLVERR  2'h2
`endif

// File: actc_pkg.sv
// Types shared by the ADC timing and resolution control block.
package actc_pkg;
  typedef enum logic [1:0] {ACTC_IDLE, ACTC_FIRST, ACTC_SECOND, ACTC_CONVERT} actc_state_t;
  typedef logic [31:0] actc_word_t;
endpackage

// File: actc_timing_control.sv
// AXI4-Lite register slave and sample sequencer with timing control.
`timescale 1ns/1ps
`include "actc_defs.svh"
module actc_timing_control (
  input  wire logic              clock,
  input  wire logic              rst_n,
  input  wire logic [7:0]        s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire actc_pkg::actc_word_t s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [7:0]        s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output actc_pkg::actc_word_t   s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  output logic                   sampleFirst,
  output logic                   sampleSecond,
  output logic                   converting,
  input  wire logic              adcBit,
  output logic [15:0]            resultData,
  output logic                   resultValid,
  output logic [2:0]             resultSlot
);
  import actc_pkg::*;

  // Software visible state.
  logic [7:0]  timingReg;      // Resolution, sample phase and divider code.
  logic        justifyRight;   // Right justification of results.
  logic        abortSeen;      // Sticky: a sequence was aborted.
  // Bus handshake state.
  logic        awHeld;         // Write address captured.
  logic        wHeld;          // Write data captured.
  logic [7:0]  awAddr;
  actc_word_t  wData;
  logic [3:0]  wStrb;
  // Sequencer state.
  actc_state_t state;
  logic [4:0]  phaseCount;     // Conversion clock periods left in phase.
  logic [9:0]  shiftReg;       // Successive result bits.
  // Next values.
  logic        next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
  logic [1:0]  next_bresp, next_rresp;
  actc_word_t  next_rdata;
  logic        next_awHeld, next_wHeld;
  logic [7:0]  next_awAddr;
  actc_word_t  next_wData;
  logic [3:0]  next_wStrb;
  logic [7:0]  next_timingReg;
  logic        next_justifyRight, next_abortSeen;
  logic        writeFire;       // A full write is performed this cycle.
  logic        abortNow;        // Abort for the sequencer.
  logic        startNow;        // Software start request.
  logic        convTick;        // One bus cycle per conversion clock period.

  actc_clock_divider #(
    .CodeWidth(5)
  ) u_div (
    .clock      (clock),
    .rst_n      (rst_n),
    .dividerCode(timingReg[`ACTC_PRS_HI:0]),
    .restart    (abortNow),
    .convTick   (convTick)
  );

  // Bus channels and register writes; each channel is taken independently.
  always_comb begin
    next_awready = 1'b0;
    next_wready  = 1'b0;
    next_arready = 1'b0;
    next_awHeld  = awHeld;
    next_wHeld   = wHeld;
    next_awAddr  = awAddr;
    next_wData   = wData;
    next_wStrb   = wStrb;
    next_bvalid  = s_axi_bvalid && !s_axi_bready;
    next_bresp   = s_axi_bresp;
    next_rvalid  = s_axi_rvalid && !s_axi_rready;
    next_rresp   = s_axi_rresp;
    next_rdata   = s_axi_rdata;
    next_timingReg    = timingReg;
    next_justifyRight = justifyRight;
    next_abortSeen    = abortSeen;
    writeFire = 1'b0;
    startNow  = 1'b0;
    if (s_axi_awvalid && s_axi_awready) begin
      next_awHeld = 1'b1;
      next_awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_wHeld = 1'b1;
      next_wData = s_axi_wdata;
      next_wStrb = s_axi_wstrb;
    end
    // Ready pulses only while the channel is empty and no response waits.
    next_awready = !next_awHeld && !s_axi_awvalid && !s_axi_bvalid ? 1'b0 :
                   (!next_awHeld && !s_axi_bvalid && !s_axi_awready);
    next_wready  = !next_wHeld && !s_axi_bvalid && !s_axi_wready && s_axi_wvalid;
    if (awHeld && wHeld && !s_axi_bvalid) begin
      writeFire   = 1'b1;
      next_awHeld = 1'b0;
      next_wHeld  = 1'b0;
      next_bvalid = 1'b1;
      next_bresp  = `ACTC_RESP_OKAY;
      unique case (awAddr)
        `ACTC_OFS_TIMING: begin
          if (wStrb[0]) next_timingReg = wData[7:0]; // R9
        end
        `ACTC_OFS_CONTROL: begin
          if (wStrb[0]) begin
            next_justifyRight = wData[`ACTC_BIT_JUSTIFY];
            startNow          = wData[`ACTC_BIT_START];
          end
        end
        `ACTC_OFS_STATUS: begin
          if (wStrb[0] && wData[0]) next_abortSeen = 1'b0;
        end
        default: next_bresp = `ACTC_RESP_SLVERR;
      endcase
    end
    // Read channel: one read at a time.
    if (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid) begin
      next_arready = 1'b1;
      next_rvalid  = 1'b1;
      next_rresp   = `ACTC_RESP_OKAY;
      unique case (s_axi_araddr)
        `ACTC_OFS_TIMING:  next_rdata = {24'h000000, timingReg}; // R9
        `ACTC_OFS_CONTROL: next_rdata = {30'h00000000, justifyRight, 1'b0};
        `ACTC_OFS_STATUS:  next_rdata = {25'h0000000, resultSlot, 2'h0, abortSeen,
                                         state != ACTC_IDLE};
        `ACTC_OFS_RESULT:  next_rdata = {16'h0000, resultData};
        default: begin
          next_rdata = 32'h00000000;
          next_rresp = `ACTC_RESP_SLVERR;
        end
      endcase
    end
    // Hardware set wins over software clear of the abort flag.
    if (abortNow && state != ACTC_IDLE) next_abortSeen = 1'b1;
  end

  // A write to the timing or control register aborts a running sequence.
  assign abortNow = writeFire && (awAddr == `ACTC_OFS_TIMING ||
                                  awAddr == `ACTC_OFS_CONTROL); // R1 R11

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `ACTC_RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rresp   <= `ACTC_RESP_OKAY;
      s_axi_rdata   <= 32'h00000000;
      awHeld        <= 1'b0;
      wHeld         <= 1'b0;
      awAddr        <= 8'h00;
      wData         <= 32'h00000000;
      wStrb         <= 4'h0;
      timingReg     <= `ACTC_TIMING_RESET; // R6 R9
      justifyRight  <= 1'b0;
      abortSeen     <= 1'b0;
    end else begin
      s_axi_awready <= next_awready;
      s_axi_wready  <= next_wready;
      s_axi_bvalid  <= next_bvalid;
      s_axi_bresp   <= next_bresp;
      s_axi_arready <= next_arready;
      s_axi_rvalid  <= next_rvalid;
      s_axi_rresp   <= next_rresp;
      s_axi_rdata   <= next_rdata;
      awHeld        <= next_awHeld;
      wHeld         <= next_wHeld;
      awAddr        <= next_awAddr;
      wData         <= next_wData;
      wStrb         <= next_wStrb;
      timingReg     <= next_timingReg;
      justifyRight  <= next_justifyRight;
      abortSeen     <= next_abortSeen;
    end
  end

  // Sequencer next state.
  actc_state_t next_state;
  logic [4:0]  next_phaseCount;
  logic [9:0]  next_shiftReg;
  logic [15:0] next_resultData;
  logic        next_resultValid;
  logic [2:0]  next_resultSlot;
  logic [4:0]  secondLen;       // Second sample phase in periods.
  logic [4:0]  convLen;         // Conversion length in periods.
  logic [9:0]  finalBits;       // Completed result including the last bit.

  always_comb begin
    secondLen = 5'h02 << timingReg[`ACTC_SMP_HI:`ACTC_SMP_LO]; // R3
    convLen   = timingReg[`ACTC_BIT_LOWRES] ? `ACTC_CONV_BITS8
                                            : `ACTC_CONV_BITS10; // R2
    finalBits = {shiftReg[8:0], adcBit};
    next_state       = state;
    next_phaseCount  = phaseCount;
    next_shiftReg    = shiftReg;
    next_resultData  = resultData;
    next_resultValid = 1'b0;
    next_resultSlot  = resultSlot;
    // A start write carries its own abort, so the start must win to launch the new sequence.
    if (startNow) begin
      next_state      = ACTC_FIRST;
      next_phaseCount = `ACTC_FIRST_PHASE; // R4
      next_resultSlot = 3'h0;            // R11
    end else if (abortNow) begin
      next_state      = ACTC_IDLE;       // R1
      next_resultSlot = 3'h0;            // R11
    end else if (convTick) begin
      unique case (state)
        ACTC_IDLE: next_state = ACTC_IDLE;
        ACTC_FIRST: begin
          next_phaseCount = phaseCount - 5'h01;
          if (phaseCount == 5'h01) begin
            next_state      = ACTC_SECOND; // R4
            next_phaseCount = secondLen;
          end
        end
        ACTC_SECOND: begin
          next_phaseCount = phaseCount - 5'h01;
          if (phaseCount == 5'h01) begin
            next_state      = ACTC_CONVERT;
            next_phaseCount = convLen;
            next_shiftReg   = 10'h000;
          end
        end
        ACTC_CONVERT: begin
          next_phaseCount = phaseCount - 5'h01;
          next_shiftReg   = finalBits;
          if (phaseCount == 5'h01) begin
            next_state       = ACTC_IDLE;
            next_resultValid = 1'b1;
            next_resultSlot  = resultSlot + 3'h1;
            // Placement by resolution and justification.
            if (timingReg[`ACTC_BIT_LOWRES]) begin
              next_resultData = justifyRight ? {8'h00, finalBits[7:0]}
                                             : {finalBits[7:0], 8'h00};
            end else begin
              next_resultData = justifyRight ? {6'h00, finalBits} // R10
                                             : {finalBits, 6'h00}; // R10
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state        <= ACTC_IDLE;
      phaseCount   <= 5'h00;
      shiftReg     <= 10'h000;
      resultData   <= 16'h0000;
      resultValid  <= 1'b0;
      resultSlot   <= 3'h0;
      sampleFirst  <= 1'b0;
      sampleSecond <= 1'b0;
      converting   <= 1'b0;
    end else begin
      state        <= next_state;
      phaseCount   <= next_phaseCount;
      shiftReg     <= next_shiftReg;
      resultData   <= next_resultData;
      resultValid  <= next_resultValid;
      resultSlot   <= next_resultSlot;
      sampleFirst  <= next_state == ACTC_FIRST;
      sampleSecond <= next_state == ACTC_SECOND;
      converting   <= next_state == ACTC_CONVERT;
    end
  end

  a_abort_idle: assert property (@(posedge clock) disable iff (!rst_n)
    (abortNow && !startNow) |=> state == ACTC_IDLE ##1 (state == ACTC_IDLE || $past(startNow))) // R1
    else $error("Abort did not leave the sequencer idle.");
  a_abort_slot: assert property (@(posedge clock) disable iff (!rst_n)
    abortNow |=> resultSlot == 3'h0) // R11
    else $error("Abort did not clear the result slot.");
  a_first_len: assert property (@(posedge clock) disable iff (!rst_n)
    ($rose(state == ACTC_FIRST)) |-> phaseCount == 5'h02) // R4
    else $error("First sample phase not two periods.");
  a_second_len: assert property (@(posedge clock) disable iff (!rst_n)
    ($rose(state == ACTC_SECOND)) |-> phaseCount == (5'h02 << timingReg[6:5])) // R3
    else $error("Second sample phase length wrong.");
  a_conv_len: assert property (@(posedge clock) disable iff (!rst_n)
    ($rose(state == ACTC_CONVERT)) |-> phaseCount == (timingReg[7] ? 5'h08 : 5'h0A)) // R2
    else $error("Conversion length does not match resolution.");
  a_left_ten: assert property (@(posedge clock) disable iff (!rst_n)
    (resultValid && !timingReg[7] && !justifyRight) |-> resultData[5:0] == 6'h00) // R10
    else $error("Left justified ten bit result misplaced.");
  a_right_ten: assert property (@(posedge clock) disable iff (!rst_n)
    (resultValid && !timingReg[7] && justifyRight) |-> resultData[15:10] == 6'h00) // R10
    else $error("Right justified ten bit result misplaced.");
  a_reset_value: assert property (@(posedge clock) disable iff (!rst_n)
    $rose(rst_n) |-> timingReg == 8'h05) // R6
    else $error("Timing register reset value wrong.");
  a_write_store: assert property (@(posedge clock) disable iff (!rst_n)
    (writeFire && awAddr == 8'h00 && wStrb[0]) |=> timingReg == $past(wData[7:0])) // R9
    else $error("Timing register write not stored.");

  c_abort_run: cover property (@(posedge clock) disable iff (!rst_n)
    abortNow && state == ACTC_CONVERT);
  c_result8: cover property (@(posedge clock) disable iff (!rst_n)
    resultValid && timingReg[7]);
  c_result10: cover property (@(posedge clock) disable iff (!rst_n)
    resultValid && !timingReg[7] && justifyRight);
endmodule // actc_timing_control

// File: tb_actc_timing_control.sv
// Self-checking bench for the ADC timing and resolution control register block.
`timescale 1ns/1ps
`include "actc_defs.svh"
module tb_actc_timing_control;
  import actc_pkg::*;
  logic       clock;          // Bus clock, 200 MHz.
  logic       rst_n;          // Asynchronous reset, active low.
  logic [7:0] awaddr;         // Write address.
  logic       awvalid;        // Write address valid.
  logic       awready;        // Write address taken.
  actc_word_t wdata;          // Write data.
  logic [3:0] wstrb;          // Write strobes.
  logic       wvalid;         // Write data valid.
  logic       wready;         // Write data taken.
  logic [1:0] bresp;          // Write response code.
  logic       bvalid;         // Write response valid.
  logic       bready;         // Write response accepted.
  logic [7:0] araddr;         // Read address.
  logic       arvalid;        // Read address valid.
  logic       arready;        // Read address taken.
  actc_word_t rdata;          // Read data.
  logic [1:0] rresp;          // Read response code.
  logic       rvalid;         // Read data valid.
  logic       rready;         // Read data accepted.
  logic       sampleFirst;    // Fixed first sample phase.
  logic       sampleSecond;   // Programmable second sample phase.
  logic       converting;     // Conversion bits running.
  logic       adcBit;         // Comparator decision fed to the sequencer.
  logic [15:0] resultData;    // Last placed result.
  logic       resultValid;    // Result completion pulse.
  logic [2:0] resultSlot;     // Result slot counter.
  int         error_cnt;      // Mismatches seen.
  int         samples_checked; // Comparisons made.

  actc_timing_control DUT (
    .clock(clock), .rst_n(rst_n),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .sampleFirst(sampleFirst), .sampleSecond(sampleSecond), .converting(converting),
    .adcBit(adcBit), .resultData(resultData), .resultValid(resultValid),
    .resultSlot(resultSlot)
  );

  // Free-running bus clock; the half period is 2.5 ns.
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  // Closing report; also reached when a bounded wait runs out.
  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Compare tasks, one per kind of result; case equality keeps unknowns from matching.
  task automatic chk32(input string what, input actc_word_t exp, input actc_word_t got);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk2(input string what, input logic [1:0] exp, input logic [1:0] got);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // A bounded wait that ran out counts as a mismatch and ends the run.
  task automatic hang(input string what);
    error_cnt++;
    $display("[ERR] %s expected handshake seen none", what);
    give_verdict();
  endtask

  // Write master: address and data offered together, each released once taken.
  task automatic axi_write(input logic [7:0] a, input actc_word_t d, output logic [1:0] r);
    int   n;
    logic awDone;
    logic wDone;
    @(posedge clock);
    awaddr <= a; awvalid <= 1'b1; wdata <= d; wstrb <= 4'hF; wvalid <= 1'b1; bready <= 1'b1;
    awDone = 1'b0; wDone = 1'b0; n = 0;
    while (!(awDone && wDone)) begin
      @(posedge clock);
      n++;
      if (n > 100) hang("write address or data");
      if (!awDone && awready === 1'b1) begin awDone = 1'b1; awvalid <= 1'b0; end
      if (!wDone && wready === 1'b1) begin wDone = 1'b1; wvalid <= 1'b0; end
    end
    // The response may already be standing at the edge that took the last channel.
    while (bvalid !== 1'b1) begin
      @(posedge clock);
      n++;
      if (n > 200) hang("write response");
    end
    r = bresp;
    bready <= 1'b0;
  endtask

  // Read master: holds the address until taken and rready until data arrives.
  task automatic axi_read(input logic [7:0] a, output actc_word_t d, output logic [1:0] r);
    int n;
    @(posedge clock);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    n = 0;
    do begin
      @(posedge clock);
      n++;
      if (n > 100) hang("read");
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  // Write one register and read it back, judging both responses and the data.
  task automatic wr_rd(input logic [7:0] a, input actc_word_t d, input actc_word_t exp);
    logic [1:0] r;
    actc_word_t got;
    axi_write(a, d, r);
    chk2("write response", `ACTC_RESP_OKAY, r);
    axi_read(a, got, r);
    chk2("read response", `ACTC_RESP_OKAY, r);
    chk32("readback", exp, got);
  endtask

  // Reset value of the timing register and an idle status with the slot counter at zero.
  task automatic t_reset();
    actc_word_t got;
    logic [1:0] r;
    axi_read(`ACTC_OFS_TIMING, got, r);
    chk32("timing reset value", 32'h00000005, got);
    axi_read(`ACTC_OFS_STATUS, got, r);
    chk32("status busy and slot", 32'h00000000, got & 32'h00000071);
    $display("test reset done");
  endtask

  // Every sample phase code, the resolution bit and both divider code boundaries read back exactly as written.
  task automatic t_fields();
    actc_word_t vals [7] = '{32'h80, 32'h00, 32'h20, 32'h40, 32'h60, 32'h1F, 32'hFF};
    foreach (vals[i]) wr_rd(`ACTC_OFS_TIMING, vals[i], vals[i]);
    $display("test fields done");
  endtask

  // Start a sequence, then count bus cycles of each phase from the edge after the response.
  task automatic run_seq(input actc_word_t tim, input actc_word_t ctl,
                         output int f, output int s, output int c);
    logic [1:0] r;
    int         n;
    axi_write(`ACTC_OFS_TIMING, tim, r);
    axi_write(`ACTC_OFS_CONTROL, ctl, r);
    f = 0;
    s = 0;
    c = 0;
    n = 0;
    do begin
      @(posedge clock);
      n++;
      if (n > 4000) hang("result pulse");
      if (sampleFirst === 1'b1) f++;
      if (sampleSecond === 1'b1) s++;
      if (converting === 1'b1) c++;
    end while (resultValid !== 1'b1);
  endtask

  // Ten-bit left-justified sequence at divider code five: 12 bus cycles a period.
  task automatic t_conv10();
    int f, s, c;
    run_seq(32'h00000005, 32'h00000001, f, s, c);
    chk32("first phase cycles", 2 * 12, f);
    chk32("second phase cycles", 2 * 12, s);
    chk32("ten bit conversion cycles", 10 * 12, c);
    chk32("ten bit left result", 32'h0000FFC0, {16'h0000, resultData});
    chk32("slot after result", 32'h00000001, {29'h0, resultSlot});
    $display("test ten bit done");
  endtask

  // Eight-bit right-justified sequence at the slowest code, 64 bus cycles a period.
  // No code brings a 200 MHz bus clock into the allowed conversion range; this comes closest.
  task automatic t_conv8();
    int f, s, c;
    run_seq(32'h000000FF, 32'h00000003, f, s, c);
    chk32("first phase cycles", 2 * 64, f);
    chk32("second phase cycles", 16 * 64, s);
    chk32("eight bit conversion cycles", 8 * 64, c);
    chk32("eight bit right result", 32'h000000FF, {16'h0000, resultData});
    $display("test eight bit done");
  endtask

  // Timing writes clear the slot counter when idle and stop a running sequence for good.
  task automatic t_abort();
    logic       active;
    logic [1:0] r;
    actc_word_t got;
    int         n;
    axi_write(`ACTC_OFS_TIMING, 32'h00000005, r);
    chk32("slot after idle abort", 32'h00000000, {29'h0, resultSlot});
    axi_write(`ACTC_OFS_CONTROL, 32'h00000001, r);
    n = 0;
    while (converting !== 1'b1) begin
      @(posedge clock);
      n++;
      if (n > 400) hang("conversion start");
    end
    axi_write(`ACTC_OFS_TIMING, 32'h000000E3, r);
    active = 1'b0;
    repeat (64) begin
      @(posedge clock);
      active = active | sampleFirst | sampleSecond | converting;
    end
    chk2("sequencer activity", 2'b00, {1'b0, active});
    axi_read(`ACTC_OFS_STATUS, got, r);
    chk32("status after abort", 32'h00000002, got & 32'h00000073);
    chk2("slot port", 2'b00, resultSlot[1:0]);
    axi_write(`ACTC_OFS_STATUS, 32'h00000001, r);
    axi_read(`ACTC_OFS_STATUS, got, r);
    chk32("status after flag clear", 32'h00000000, got & 32'h00000073);
    $display("test abort done");
  endtask

  // Control register keeps the justify bit and reads the start bit as zero.
  task automatic t_control();
    wr_rd(`ACTC_OFS_CONTROL, 32'h00000003, 32'h00000002);
    wr_rd(`ACTC_OFS_CONTROL, 32'h00000000, 32'h00000000);
    $display("test control done");
  endtask

  // Unmapped place is refused both ways and leaves the timing register alone.
  task automatic t_unmapped();
    logic [1:0] r;
    actc_word_t got;
    wr_rd(`ACTC_OFS_TIMING, 32'h0000002A, 32'h0000002A);
    axi_write(8'h10, 32'h000000FF, r);
    chk2("unmapped write response", `ACTC_RESP_SLVERR, r);
    axi_read(8'h10, got, r);
    chk2("unmapped read response", `ACTC_RESP_SLVERR, r);
    chk32("unmapped read data", 32'h00000000, got);
    axi_read(`ACTC_OFS_TIMING, got, r);
    chk32("timing after unmapped", 32'h0000002A, got);
    $display("test unmapped done");
  endtask

  // A second reset in mid-run brings the divider code back to five.
  task automatic t_rereset();
    actc_word_t got;
    logic [1:0] r;
    @(posedge clock);
    rst_n <= 1'b0;
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    axi_read(`ACTC_OFS_TIMING, got, r);
    chk32("timing after second reset", 32'h00000005, got);
    $display("test second reset done");
  endtask

  // Main sequence: reset for two cycles, then each scenario in turn.
  initial begin
    error_cnt = 0;
    samples_checked = 0;
    rst_n = 1'b0;
    awaddr = 8'h00; awvalid = 1'b0; wdata = 32'h0; wstrb = 4'h0; wvalid = 1'b0;
    bready = 1'b0; araddr = 8'h00; arvalid = 1'b0; rready = 1'b0; adcBit = 1'b0;
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    adcBit <= 1'b1;
    t_reset();
    t_fields();
    t_conv10();
    t_conv8();
    t_abort();
    t_control();
    t_unmapped();
    t_rereset();
    give_verdict();
  end
endmodule // tb_actc_timing_control
